//--- core/stx_pkg.sv
// Package with register map, field positions, reset values and types of the serial transmit block.
package stx_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] STX_OFS_CTRL_STATUS = 12'h000;
  localparam logic [11:0] STX_OFS_DATA        = 12'h004;
  localparam logic [11:0] STX_OFS_BAUD        = 12'h008;
  localparam logic [11:0] STX_OFS_RX_CTRL     = 12'h00C;

  // ---------------------------------------------------------------------------
  // Control/status, receive control and baud field positions
  // ---------------------------------------------------------------------------
  localparam int STX_BIT_CLK_MASTER = 7;
  localparam int STX_BIT_NINE_BIT   = 6;
  localparam int STX_BIT_TX_ENABLE  = 5;
  localparam int STX_BIT_SYNC_MODE  = 4;
  localparam int STX_BIT_BREAK_REQ  = 3;
  localparam int STX_BIT_HIGH_SPEED = 2;
  localparam int STX_BIT_SHIFT_EMPTY = 1;
  localparam int STX_BIT_NINTH_DATA = 0;
  localparam int STX_BIT_RX_SINGLE  = 1;
  localparam int STX_BIT_RX_CONT    = 0;
  localparam int STX_BIT_BAUD_AUTO  = 16;

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  STX_RST_CTRL = 8'h02;
  localparam logic [15:0] STX_RST_BAUD = 16'h000F;
  localparam int          STX_BREAK_BITS = 13;
  localparam int          STX_HS_DIV = 4;
  localparam int          STX_LS_DIV = 16;

  typedef enum logic [1:0] {
    STX_IDLE  = 2'b00,
    STX_SHIFT = 2'b01,
    STX_BREAK = 2'b10
  } stx_state_t;

  typedef struct packed {
    logic       clk_master;
    logic       nine_bit;
    logic       tx_enable;
    logic       sync_mode;
    logic       break_req;
    logic       high_speed;
    logic       shift_empty;
    logic       ninth_data;
  } stx_ctrl_t;
endpackage

//--- core/stx_fifo.sv
// No logic here; the transmit FIFO module sits in the core file with the rest of the design.

//--- core/stx_core.sv
// Serial transmit block with control/status register, APB slave, FIFO and shifter.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module stx_core
  import stx_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        auto_baud_valid,
  input  wire logic [15:0] auto_baud_value,
  input  wire logic        ext_clk_in,
  output logic             tx_out,
  output logic             tx_clk_out,
  output logic             tx_clk_oe_n
);
  // The FIFO needs at least two words and a power-of-two depth for its wrap bit.
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_check
    $error("stx_core: FIFO_DEPTH must be a power of two of at least two");
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  stx_ctrl_t   ctrl;
  logic [15:0] baud;
  logic        baud_auto_en;
  logic [1:0]  rx_en;
  stx_state_t  state;
  logic [9:0]  shreg;
  logic [3:0]  bits_left;
  logic [15:0] baud_cnt;
  logic [4:0]  sub_cnt;
  logic        tick;
  logic [2:0]  ext_sync;
  logic        ext_stable;
  logic        ext_prev;
  logic        break_done;

  wire apb_setup  = psel && !penable;
  wire apb_access = psel && penable;
  wire apb_wr     = apb_access && pwrite;
  // Writes take effect only at the completing edge, never during a held access.
  wire wr_done    = apb_wr && pready;
  wire wr_ctrl    = wr_done && paddr == STX_OFS_CTRL_STATUS;
  wire wr_data    = wr_done && paddr == STX_OFS_DATA;
  wire mapped     = paddr == STX_OFS_CTRL_STATUS || paddr == STX_OFS_DATA ||
                    paddr == STX_OFS_BAUD || paddr == STX_OFS_RX_CTRL;

  // Receive enables win in synchronous mode, so the transmitter sits idle.
  wire tx_run = ctrl.tx_enable && !(ctrl.sync_mode && |rx_en);

  // ---------------------------------------------------------------------------
  // FIFO between the data register and the shifter
  // ---------------------------------------------------------------------------
  logic [8:0] fifo_out;
  logic       fifo_valid;
  logic       fifo_in_ready;
  wire        start_char = state == STX_IDLE && tx_run && fifo_valid;

  stx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   ({ctrl.ninth_data, pwdata[7:0]}),
    .in_valid  (wr_data),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (start_char)
  );

  // ---------------------------------------------------------------------------
  // APB slave: wait states while a data write finds the FIFO full
  // ---------------------------------------------------------------------------
  // Holding the access instead of dropping the word keeps software from losing data.
  wire data_hold = pwrite && paddr == STX_OFS_DATA && !fifo_in_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= (apb_setup || (apb_access && !pready)) && !data_hold;
      pslverr <= (apb_setup || apb_access) && !mapped;
      if (apb_setup || (apb_access && !pready)) begin
        case (paddr)
          STX_OFS_CTRL_STATUS: prdata <= {24'h00_0000, ctrl};
          STX_OFS_BAUD:        prdata <= {15'h0000, baud_auto_en, baud};
          STX_OFS_RX_CTRL:     prdata <= {30'h0000_0000, rx_en};
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control register; hardware clear of break request wins over the write
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= stx_ctrl_t'(STX_RST_CTRL);
    end else begin
      if (wr_ctrl) begin
        ctrl.clk_master <= pwdata[STX_BIT_CLK_MASTER];
        ctrl.nine_bit   <= pwdata[STX_BIT_NINE_BIT];
        ctrl.tx_enable  <= pwdata[STX_BIT_TX_ENABLE];
        ctrl.sync_mode  <= pwdata[STX_BIT_SYNC_MODE];
        ctrl.break_req  <= pwdata[STX_BIT_BREAK_REQ];
        ctrl.high_speed <= pwdata[STX_BIT_HIGH_SPEED];
        ctrl.ninth_data <= pwdata[STX_BIT_NINTH_DATA];
      end
      if (break_done) ctrl.break_req <= 1'b0;
      ctrl.shift_empty <= state == STX_IDLE && !start_char;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud         <= STX_RST_BAUD;
      baud_auto_en <= 1'b0;
      rx_en        <= 2'b00;
    end else begin
      if (wr_done && paddr == STX_OFS_BAUD) begin
        baud         <= pwdata[15:0];
        baud_auto_en <= pwdata[STX_BIT_BAUD_AUTO];
      end else if (baud_auto_en && auto_baud_valid) begin
        baud <= auto_baud_value;
      end
      if (wr_done && paddr == STX_OFS_RX_CTRL) rx_en <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Bit timing: internal baud generator, or external clock in sync slave mode
  // ---------------------------------------------------------------------------
  wire       slave_clk = ctrl.sync_mode && !ctrl.clk_master;
  wire [4:0] sub_top   = ctrl.sync_mode ? 5'd1 : (ctrl.high_speed ? 5'(STX_HS_DIV - 1) : 5'(STX_LS_DIV - 1));
  wire       gen_tick  = baud_cnt == 16'h0000 && sub_cnt == sub_top;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync   <= 3'b000;
      ext_stable <= 1'b0;
      ext_prev   <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_clk_in};
      if (ext_sync[1] == ext_sync[2]) ext_stable <= ext_sync[2];
      ext_prev <= ext_stable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt <= 16'h0000;
      sub_cnt  <= 5'd0;
    end else if (baud_cnt == 16'h0000) begin
      baud_cnt <= baud;
      sub_cnt  <= (sub_cnt >= sub_top) ? 5'd0 : sub_cnt + 5'd1;
    end else begin
      baud_cnt <= baud_cnt - 16'h0001;
    end
  end

  // Slave shifts on the falling external edge; master on its own generator.
  always_comb begin
    tick = slave_clk ? (ext_prev && !ext_stable) : gen_tick;
  end

  // ---------------------------------------------------------------------------
  // Shifter
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= STX_IDLE;
      shreg      <= 10'h3FF;
      bits_left  <= 4'd0;
      break_done <= 1'b0;
      tx_out     <= 1'b1;
    end else begin
      break_done <= 1'b0;
      case (state)
        STX_IDLE: begin
          tx_out <= 1'b1;
          if (start_char && ctrl.break_req && !ctrl.sync_mode) begin
            state     <= STX_BREAK;
            bits_left <= 4'(STX_BREAK_BITS);
            shreg     <= 10'h3FF;
          end else if (start_char && ctrl.sync_mode) begin
            state     <= STX_SHIFT;
            shreg     <= {1'b1, ctrl.nine_bit ? fifo_out[8] : 1'b1, fifo_out[7:0]};
            bits_left <= ctrl.nine_bit ? 4'd9 : 4'd8;
          end else if (start_char) begin
            state     <= STX_SHIFT;
            shreg     <= {ctrl.nine_bit ? fifo_out[8] : 1'b1, fifo_out[7:0], 1'b0};
            bits_left <= ctrl.nine_bit ? 4'd11 : 4'd10;
          end
        end
        STX_SHIFT: begin
          if (!tx_run) begin
            state <= STX_IDLE;
          end else if (tick) begin
            tx_out    <= shreg[0];
            shreg     <= {1'b1, shreg[9:1]};
            bits_left <= bits_left - 4'd1;
            if (bits_left == 4'd0) state <= STX_IDLE;
          end
        end
        STX_BREAK: begin
          if (tick) begin
            tx_out    <= (bits_left == 4'd0) ? 1'b1 : 1'b0;
            bits_left <= bits_left - 4'd1;
            if (bits_left == 4'd0) begin
              state      <= STX_IDLE;
              break_done <= 1'b1;
            end
          end
        end
        default: state <= STX_IDLE;
      endcase
    end
  end

  // Master drives the shift clock only while tx_run is high; slave and async leave it undriven.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clk_out  <= 1'b1;
      tx_clk_oe_n <= 1'b1;
    end else begin
      tx_clk_oe_n <= !(ctrl.sync_mode && ctrl.clk_master && tx_run);
      if (gen_tick && state == STX_SHIFT) tx_clk_out <= !tx_clk_out;
      else if (state != STX_SHIFT) tx_clk_out <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_break_start;
    state == STX_IDLE && start_char && ctrl.break_req && !ctrl.sync_mode;
  endsequence

  a_break_enters: assert property (@(posedge pclk) disable iff (!presetn) s_break_start |=> state == STX_BREAK) else $error("break not started");
  a_break_clears: assert property (@(posedge pclk) disable iff (!presetn) break_done && !wr_done |=> !ctrl.break_req) else $error("break request not cleared");
  a_sync_no_break: assert property (@(posedge pclk) disable iff (!presetn) ctrl.sync_mode && state == STX_IDLE |=> state != STX_BREAK) else $error("break in sync mode");
  a_tx_disabled: assert property (@(posedge pclk) disable iff (!presetn) !ctrl.tx_enable && state == STX_IDLE |=> state == STX_IDLE) else $error("shift while disabled");
  a_rx_override: assert property (@(posedge pclk) disable iff (!presetn) ctrl.sync_mode && |rx_en && state == STX_IDLE |=> state == STX_IDLE) else $error("rx enable ignored");
  a_nine_bit_len: assert property (@(posedge pclk) disable iff (!presetn) start_char && !ctrl.break_req && !ctrl.sync_mode && ctrl.nine_bit |=> bits_left == 4'd11) else $error("nine-bit length");
  a_eight_bit_len: assert property (@(posedge pclk) disable iff (!presetn) start_char && !ctrl.sync_mode && !ctrl.break_req && !ctrl.nine_bit |=> bits_left == 4'd10) else $error("eight-bit length");
  a_master_clk_oe: assert property (@(posedge pclk) disable iff (!presetn) ctrl.sync_mode && !ctrl.clk_master |=> tx_clk_oe_n) else $error("slave drives clock");
  a_auto_baud: assert property (@(posedge pclk) disable iff (!presetn) baud_auto_en && auto_baud_valid && !wr_done |=> baud == $past(auto_baud_value)) else $error("auto baud not loaded");
endmodule

// ---------------------------------------------------------------------------
// Transmit FIFO
// ---------------------------------------------------------------------------
// One spare pointer bit tells full from empty without a separate counter.
module stx_fifo
  import stx_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("stx_fifo: DEPTH must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge pclk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) wr_ptr <= wr_ptr + 1'b1;
      if (out_ready && !empty) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

//--- verification/stx_rx_model.sv
// Behavioural far-end serial receiver that decodes frames leaving the transmit line.
`timescale 1ns/1ps
module stx_rx_model (
  input  wire logic       pclk,
  input  wire logic       line,
  input  wire logic       nine,
  input  wire logic [31:0] bit_cyc,
  output logic [8:0]      word,
  output int              count,
  output logic            frame_err
);
  // The bit period is the far end's own reference, known independently of the sender.
  initial begin
    logic [8:0] w;
    int         i;
    word = 9'h000;
    count = 0;
    frame_err = 1'b0;
    forever begin
      @(negedge line);
      repeat (bit_cyc / 2) @(posedge pclk);
      if (line === 1'b0) begin
        w = 9'h000;
        for (i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (bit_cyc) @(posedge pclk);
          w[i] = line;
        end
        repeat (bit_cyc) @(posedge pclk);
        // A low stop sample marks a break or a frame cut short.
        frame_err = (line !== 1'b1);
        word = w;
        count++;
        wait (line === 1'b1);
      end
    end
  end
endmodule

//--- verification/tb.sv
// Self-checking testbench for the serial transmit block.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t got %h expected %h", $time, (a), (b)); end end
module tb;
  import stx_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, tx_out, tx_clk_out, tx_clk_oe_n, m_nine = 1'b0, frerr;
  logic        ab_valid = 1'b0, ext_clk = 1'b1, ext_run = 1'b0, clk_prev = 1'b1;
  logic [15:0] ab_value = 16'h0000;
  logic [8:0]  mword;
  int          fail_count = 0, num_checks = 0, cycles = 0, oe_cnt = 0, clk_falls = 0, mcount, i, base;
  stx_core #(.FIFO_DEPTH(16)) stx_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .auto_baud_valid(ab_valid), .auto_baud_value(ab_value),
    .ext_clk_in(ext_clk), .tx_out(tx_out), .tx_clk_out(tx_clk_out), .tx_clk_oe_n(tx_clk_oe_n));
  stx_rx_model stx_rx_model_inst (.pclk(pclk), .line(tx_out), .nine(m_nine), .bit_cyc(8),
    .word(mword), .count(mcount), .frame_err(frerr));
  always #20 pclk = ~pclk;
  // ---------------------------------------------------------------------------
  // Watchers
  // ---------------------------------------------------------------------------
  // Slow external shift clock, well under the three-flop synchroniser's limit.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (!tx_clk_oe_n) oe_cnt <= oe_cnt + 1;
    // Shift clock falls count only while the block drives the pin.
    clk_prev <= tx_clk_out;
    if (!tx_clk_oe_n && clk_prev && !tx_clk_out) clk_falls <= clk_falls + 1;
    if (ext_run && cycles % 8 == 0) ext_clk <= ~ext_clk;
    if (cycles == 60000) begin
      fail_count++;
      test_done();
    end
  end
  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait for the slave.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_frames(input int target);
    int n;
    n = 0;
    while (mcount < target && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(mcount, target)
  endtask
  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (tx_clk_oe_n !== lvl && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(tx_clk_oe_n, lvl)
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset_map();
    apb(1'b0, STX_OFS_CTRL_STATUS, 32'h0);
    `CHK(rdat[7:0], STX_RST_CTRL)
    apb(1'b0, STX_OFS_BAUD, 32'h0);
    `CHK(rdat[15:0], STX_RST_BAUD)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
  endtask
  task automatic t_async_frames();
    // Clock master bit set in async mode must not drive the clock pin.
    base = oe_cnt;
    apb(1'b1, STX_OFS_BAUD, 32'h0000_0001);
    apb(1'b1, STX_OFS_CTRL_STATUS, 32'h0000_00A4);
    apb(1'b1, STX_OFS_DATA, 32'h0000_00A5);
    apb(1'b0, STX_OFS_CTRL_STATUS, 32'h0);
    `CHK(rdat[STX_BIT_SHIFT_EMPTY], 1'b0)
    wait_frames(1);
    `CHK({frerr, mword[7:0]}, {1'b0, 8'hA5})
    `CHK(oe_cnt, base)
    m_nine = 1'b1;
    apb(1'b1, STX_OFS_CTRL_STATUS, 32'h0000_0065);
    apb(1'b1, STX_OFS_DATA, 32'h0000_003C);
    wait_frames(2);
    `CHK({frerr, mword}, {1'b0, 9'h13C})
    m_nine = 1'b0;
  endtask
  task automatic t_fill_hold();
    apb(1'b1, STX_OFS_CTRL_STATUS, 32'h0000_0004);
    for (i = 0; i < 16; i++) apb(1'b1, STX_OFS_DATA, i);
    repeat (200) @(posedge pclk);
    `CHK({mcount, tx_out}, {32'sd2, 1'b1})
    apb(1'b1, STX_OFS_CTRL_STATUS, 32'h0000_0024);
    // One word has left, so this write fills the FIFO and the next one is held until another leaves.
    apb(1'b1, STX_OFS_DATA, 32'h0000_00EE);
    base = cycles;
    apb(1'b1, STX_OFS_DATA, 32'h0000_00EF);
    `CHK(cycles - base > 8, 1'b1)
    wait_frames(20);
    `CHK(mword[7:0], 8'hEF)
  endtask
  task automatic t_break();
    apb(1'b1, STX_OFS_CTRL_STATUS, 32'h0000_002C);
    apb(1'b1, STX_OFS_DATA, 32'h0000_0000);
    wait_frames(21);
    `CHK(frerr, 1'b1)
    repeat (40) @(posedge pclk);
    apb(1'b0, STX_OFS_CTRL_STATUS, 32'h0);
    `CHK(rdat[STX_BIT_BREAK_REQ], 1'b0)
  endtask
  task automatic t_sync();
    apb(1'b1, STX_OFS_RX_CTRL, 32'h0000_0001);
    apb(1'b1, STX_OFS_CTRL_STATUS, 32'h0000_00B0);
    apb(1'b1, STX_OFS_DATA, 32'h0000_005A);
    repeat (100) @(posedge pclk);
    apb(1'b0, STX_OFS_CTRL_STATUS, 32'h0);
    `CHK({tx_clk_oe_n, rdat[STX_BIT_SHIFT_EMPTY]}, 2'b11)
    base = clk_falls;
    apb(1'b1, STX_OFS_RX_CTRL, 32'h0000_0000);
    wait_oe(1'b0);
    repeat (100) @(posedge pclk);
    // The master keeps driving its clock pin while the transmitter stays enabled.
    apb(1'b0, STX_OFS_CTRL_STATUS, 32'h0);
    `CHK({tx_clk_oe_n, rdat[STX_BIT_SHIFT_EMPTY], clk_falls > base}, 3'b011)
    ext_run <= 1'b1;
    apb(1'b1, STX_OFS_CTRL_STATUS, 32'h0000_0030);
    wait_oe(1'b1);
    base = oe_cnt;
    apb(1'b1, STX_OFS_DATA, 32'h0000_00C3);
    apb(1'b0, STX_OFS_CTRL_STATUS, 32'h0);
    `CHK(rdat[STX_BIT_SHIFT_EMPTY], 1'b0)
    repeat (400) @(posedge pclk);
    apb(1'b0, STX_OFS_CTRL_STATUS, 32'h0);
    `CHK({oe_cnt, rdat[STX_BIT_SHIFT_EMPTY]}, {base, 1'b1})
  endtask
  task automatic t_auto_baud();
    // Auto-baud values are ignored until the auto enable bit is set, then they load the baud register.
    apb(1'b1, STX_OFS_BAUD, 32'h0000_0001);
    ab_value <= 16'h0005;
    ab_valid <= 1'b1;
    @(posedge pclk);
    ab_valid <= 1'b0;
    apb(1'b0, STX_OFS_BAUD, 32'h0);
    `CHK(rdat[16:0], 17'h00001)
    apb(1'b1, STX_OFS_BAUD, 32'h0001_0001);
    ab_value <= 16'h0003;
    ab_valid <= 1'b1;
    @(posedge pclk);
    ab_valid <= 1'b0;
    apb(1'b0, STX_OFS_BAUD, 32'h0);
    `CHK(rdat[16:0], 17'h10003)
  endtask
  task automatic test_done();
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_map();
    t_async_frames();
    t_fill_hold();
    t_break();
    t_sync();
    t_auto_baud();
    test_done();
  end
endmodule
